/* File: rtl/bssr_regs.sv */
// register bank holding buck converter settings and switcher mode control
// assumes a host port that gives one-cycle write and read strobes on mclk,
// a startup sequencer on mclk, and reset pins asynchronous to mclk

`timescale 1ns/1ps

// Behaviour
// - second converter normal setting, bits 0-4, unreset
// - second converter scaling setting, bits 5-9, unreset
// - second converter standby setting, bits 10-14, unreset
// - low-load maximum, bits 15-18, system reset 1010
// - low-load minimum, bits 19-22, system reset 1000
// - second converter range select bit 23, unreset
// - third converter normal and spare bits, unreset
// - third converter standby setting, bits 10-14, unreset
// - third register bits 15-22 zero, bit 23 range
// - fourth converter normal and spare bits, unreset
// - fourth converter standby setting, bits 10-14, unreset
// - fourth register bits 15-22 zero, bit 23 range
// - first memory hold bit 4, power-off reset only
// - first speed 01, low-load enable 0, bit 9 zero
// - second memory hold bit 14, power-off reset clears
// - second speed bits 16-17, system reset 01
// - pll enable 0, multiplier 100 on system reset
// - current-limit disable cleared, bit 23 reads zero
// - startup restores modes; enabled converters run pwm
module bssr_regs
  import bssr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic system_reset_n,
  input wire logic power_off_reset_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [23:0] reg_wdata,
  output logic [23:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic seq_restore,
  input wire logic [1:0] buck_startup_enable,
  input wire bssr_buck_two_type cfg_buck_two,
  input wire bssr_buck_lo_type cfg_buck_three,
  input wire bssr_buck_lo_type cfg_buck_four,
  output bssr_buck_two_type buck_two_set,
  output bssr_buck_lo_type buck_three_set,
  output bssr_buck_lo_type buck_four_set,
  output bssr_mode_ctl_type switcher_mode
);

  // ----------------------------------------------------------------
  // reset pin synchronisation
  // ----------------------------------------------------------------
  logic [1:0] pin_n; // filtered reset pins, bit 1 power-off, bit 0 system
  logic sys_rst_act; // system reset held active
  logic off_rst_act; // power-off reset held active

  // both pins idle high, so the filter starts released
  bssr_pin_sync #(
    .WIDTH(2),
    .IDLE(2'h3)
  ) u_pin_sync (
    .mclk(mclk),
    .rst(rst),
    .pin_in({power_off_reset_n, system_reset_n}),
    .pin_out(pin_n)
  );

  assign sys_rst_act = ~pin_n[0];
  assign off_rst_act = ~pin_n[1];

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  bssr_buck_two_type two_q, two_d; // second converter
  bssr_buck_lo_type three_q, three_d; // third converter
  bssr_buck_lo_type four_q, four_d; // fourth converter
  bssr_mode_ctl_type mode_q, mode_d; // mode control

  // next values; later sources win: host write, startup, system, power-off, rst
  always_comb begin
    two_d = two_q;
    three_d = three_q;
    four_d = four_q;
    mode_d = mode_q;
    // host writes; read-only bits are masked off so they stay zero
    if (reg_wr) begin
      case (reg_addr)
        BSSR_ADDR_BUCK_TWO: begin
          two_d = bssr_buck_two_type'(reg_wdata);
        end
        BSSR_ADDR_BUCK_THREE: begin
          three_d = bssr_buck_lo_type'(reg_wdata & BSSR_LO_WMASK);
        end
        BSSR_ADDR_BUCK_FOUR: begin
          four_d = bssr_buck_lo_type'(reg_wdata & BSSR_LO_WMASK);
        end
        BSSR_ADDR_MODE: begin
          mode_d = bssr_mode_ctl_type'(reg_wdata & BSSR_MODE_WMASK);
        end
        default: begin
          // unmapped address: write dropped
        end
      endcase
    end
    // startup restore of operating modes; enabled ones get pwm in both states
    if (seq_restore) begin
      mode_d.mode1 = buck_startup_enable[0] ? BSSR_MODE_RST : BSSR_MODE_OFF;
      mode_d.mode2 = buck_startup_enable[1] ? BSSR_MODE_RST : BSSR_MODE_OFF;
    end
    // system reset: only fields that name it as their source
    if (sys_rst_act) begin
      two_d.low_load_max = BSSR_LOW_LOAD_MAX_RST;
      two_d.low_load_min = BSSR_LOW_LOAD_MIN_RST;
      mode_d.mode1 = BSSR_MODE_RST;
      mode_d.speed1 = BSSR_SPEED_RST;
      mode_d.low_load_scaling_enable = BSSR_BIT_CLR;
      mode_d.mode2 = BSSR_MODE_RST;
      mode_d.speed2 = BSSR_SPEED_RST;
      mode_d.pll_en = BSSR_BIT_CLR;
      mode_d.pll_mult = BSSR_PLL_MULT_RST;
      mode_d.ilim_dis = BSSR_BIT_CLR;
    end
    // power-off reset: hold and user-off bits survive a system reset
    if (off_rst_act) begin
      mode_d.mh1 = BSSR_BIT_CLR;
      mode_d.uo1 = BSSR_BIT_CLR;
      mode_d.mh2 = BSSR_BIT_CLR;
      mode_d.uo2 = BSSR_BIT_CLR;
    end
    // power-up of the core: reset-sourced fields to defaults,
    // unreset fields take the power-up configuration once
    if (rst) begin
      two_d = cfg_buck_two;
      two_d.low_load_max = BSSR_LOW_LOAD_MAX_RST;
      two_d.low_load_min = BSSR_LOW_LOAD_MIN_RST;
      three_d = bssr_buck_lo_type'(cfg_buck_three & BSSR_LO_WMASK);
      four_d = bssr_buck_lo_type'(cfg_buck_four & BSSR_LO_WMASK);
      mode_d = '0;
      mode_d.mode1 = BSSR_MODE_RST;
      mode_d.speed1 = BSSR_SPEED_RST;
      mode_d.mode2 = BSSR_MODE_RST;
      mode_d.speed2 = BSSR_SPEED_RST;
      mode_d.pll_mult = BSSR_PLL_MULT_RST;
    end
  end

  // registers only
  always_ff @(posedge mclk) begin
    two_q <= two_d;
    three_q <= three_d;
    four_q <= four_d;
    mode_q <= mode_d;
  end

  // settings go straight to the converters from the flops
  assign buck_two_set = two_q;
  assign buck_three_set = three_q;
  assign buck_four_set = four_q;
  assign switcher_mode = mode_q;

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [23:0] rd_view; // word selected by the read address
  logic [23:0] rdata_q, rdata_d; // held read data
  logic rvalid_q, rvalid_d; // one-cycle read answer

  // address decode; unmapped addresses read as zero
  always_comb begin
    case (reg_addr)
      BSSR_ADDR_BUCK_TWO: rd_view = two_q;
      BSSR_ADDR_BUCK_THREE: rd_view = three_q;
      BSSR_ADDR_BUCK_FOUR: rd_view = four_q;
      BSSR_ADDR_MODE: rd_view = mode_q;
      default: rd_view = 24'h000000;
    endcase
  end

  // data holds until the next read so a slow host can take it late
  always_comb begin
    rdata_d = reg_rd ? rd_view : rdata_q;
    rvalid_d = reg_rd;
    if (rst) begin
      rdata_d = 24'h000000;
      rvalid_d = 1'b0;
    end
  end

  // registers only
  always_ff @(posedge mclk) begin
    rdata_q <= rdata_d;
    rvalid_q <= rvalid_d;
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_three_ro_zero: assert property (three_q.zero == 8'h00)
    else $error("third register read-only bits not zero");

  a_four_ro_zero: assert property (four_q.zero == 8'h00)
    else $error("fourth register read-only bits not zero");

  a_mode_rsvd_zero: assert property (!mode_q.rsvd_lo && !mode_q.rsvd_hi)
    else $error("mode register reserved bits not zero");

  a_sysrst_low_max: assert property (sys_rst_act |=> two_q.low_load_max == 4'ha)
    else $error("low-load maximum not loaded by system reset");

  a_sysrst_low_min: assert property (sys_rst_act |=> two_q.low_load_min == 4'h8)
    else $error("low-load minimum not loaded by system reset");

  a_sysrst_keeps_set: assert property ((sys_rst_act && !reg_wr) |=>
    $stable(two_q.normal) && $stable(two_q.scaling) && $stable(two_q.stby) &&
    $stable(two_q.range_sel) && $stable(three_q) && $stable(four_q))
    else $error("system reset disturbed an unreset setting");

  a_sysrst_pll: assert property (sys_rst_act |=>
    !mode_q.pll_en && mode_q.pll_mult == 3'h4 && !mode_q.ilim_dis &&
    mode_q.speed1 == 2'h1 && mode_q.speed2 == 2'h1 && !mode_q.low_load_scaling_enable)
    else $error("system reset defaults wrong in mode register");

  a_offrst_clear: assert property (off_rst_act |=>
    !mode_q.mh1 && !mode_q.uo1 && !mode_q.mh2 && !mode_q.uo2)
    else $error("power-off reset left a hold or user-off bit set");

  a_sysrst_keeps_hold: assert property ((sys_rst_act && !off_rst_act && !reg_wr) |=>
    $stable(mode_q.mh1) && $stable(mode_q.uo1) && $stable(mode_q.mh2) && $stable(mode_q.uo2))
    else $error("system reset changed a hold or user-off bit");

  a_write_three: assert property ((reg_wr && reg_addr == BSSR_ADDR_BUCK_THREE) |=>
    three_q.normal == $past(reg_wdata[4:0]) && three_q.spare == $past(reg_wdata[9:5]) &&
    three_q.range_sel == $past(reg_wdata[23]))
    else $error("third register write not stored");

  a_restore_mode: assert property ((seq_restore && !sys_rst_act) |=>
    mode_q.mode2 == ($past(buck_startup_enable[1]) ? 4'ha : 4'h0))
    else $error("startup restore gave wrong mode");

  a_read_answer: assert property (reg_rd |=> reg_rvalid && reg_rdata == $past(rd_view))
    else $error("read answer missing or wrong");

  // ----------------------------------------------------------------
  // host writes, remaining reset sources and the idle read port
  // ----------------------------------------------------------------
  // system reset returns both operating modes to pwm in both states;
  // a write in the same cycle loses, so the modes are checked outright
  a_sysrst_modes: assert property (sys_rst_act |=>
    mode_q.mode1 == 4'ha && mode_q.mode2 == 4'ha)
    else $error("system reset left an operating mode wrong");

  // power-off reset alone leaves the system-reset fields where they are
  a_offrst_keeps_sys: assert property ((off_rst_act && !sys_rst_act && !reg_wr) &&
    !seq_restore |=> $stable(mode_q.mode1) && $stable(mode_q.mode2) &&
    $stable(mode_q.pll_mult))
    else $error("power-off reset changed a system-reset field");

  // the unreset fields of the second register follow the host word; the low-load fields are not checked
  a_write_two: assert property ((reg_wr && reg_addr == BSSR_ADDR_BUCK_TWO) |=>
    two_q.normal == $past(reg_wdata[4:0]) && two_q.scaling == $past(reg_wdata[9:5]) &&
    two_q.stby == $past(reg_wdata[14:10]) && two_q.range_sel == $past(reg_wdata[23]))
    else $error("second register write not stored");

  // fourth register keeps what was written, read-only bits aside
  a_write_four: assert property ((reg_wr && reg_addr == BSSR_ADDR_BUCK_FOUR) |=>
    four_q.normal == $past(reg_wdata[4:0]) && four_q.spare == $past(reg_wdata[9:5]) &&
    four_q.stby == $past(reg_wdata[14:10]) && four_q.range_sel == $past(reg_wdata[23]))
    else $error("fourth register write not stored");

  // with no other source active a mode write lands whole, bits 9 and 23 dropped
  a_write_mode: assert property ((reg_wr && reg_addr == BSSR_ADDR_MODE) &&
    !seq_restore && !sys_rst_act && !off_rst_act |=>
    mode_q == bssr_mode_ctl_type'($past(reg_wdata) & 24'h7ffdff))
    else $error("mode register write not stored");

  // unreset fields move only on a host write or a core power-up
  a_unreset_stable: assert property (!reg_wr |=>
    $stable(two_q.normal) && $stable(two_q.scaling) && $stable(two_q.stby) &&
    $stable(two_q.range_sel) && $stable(three_q) && $stable(four_q))
    else $error("unreset field changed without a host write");

  // read data holds between reads so a slow host still sees its word
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  // a stray answer would let a host take stale data as fresh
  a_rvalid_only: assert property (!reg_rd |=> !reg_rvalid)
    else $error("read answer without a read");

  c_mode_write: cover property (reg_wr && reg_addr == BSSR_ADDR_MODE ##2 reg_rd);
  c_sysrst_release: cover property (sys_rst_act ##1 !sys_rst_act);
  c_offrst: cover property (off_rst_act && !sys_rst_act);
  c_restore: cover property (seq_restore && buck_startup_enable == 2'h3);

endmodule

/* File: rtl/bssr_pkg.sv */
// package for the buck switcher setting register bank
// assumes one clock domain and a byte-wide register address from the host port

package bssr_pkg;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] BSSR_ADDR_BUCK_TWO = 8'h19; // second converter settings
  localparam logic [7:0] BSSR_ADDR_BUCK_THREE = 8'h1a; // third converter settings
  localparam logic [7:0] BSSR_ADDR_BUCK_FOUR = 8'h1b; // fourth converter settings
  localparam logic [7:0] BSSR_ADDR_MODE = 8'h1c; // switcher mode control

  // ----------------------------------------------------------------
  // reset values and write masks
  // ----------------------------------------------------------------
  localparam logic [3:0] BSSR_LOW_LOAD_MAX_RST = 4'ha; // low-load maximum level
  localparam logic [3:0] BSSR_LOW_LOAD_MIN_RST = 4'h8; // low-load minimum level
  localparam logic [3:0] BSSR_MODE_RST = 4'ha; // operating mode, pwm in both states
  localparam logic [3:0] BSSR_MODE_OFF = 4'h0; // mode left by startup on a disabled converter
  localparam logic [1:0] BSSR_SPEED_RST = 2'h1; // scaling speed
  localparam logic [2:0] BSSR_PLL_MULT_RST = 3'h4; // pll multiplication factor
  localparam logic BSSR_BIT_CLR = 1'b0; // single control bit cleared
  localparam logic [23:0] BSSR_LO_WMASK = 24'h807fff; // writable bits, third and fourth
  localparam logic [23:0] BSSR_MODE_WMASK = 24'h7ffdff; // writable bits, mode control

  // ----------------------------------------------------------------
  // register layouts, most significant field first
  // ----------------------------------------------------------------
  typedef struct packed {
    logic range_sel; // bit 23
    logic [3:0] low_load_min; // bits 22..19, leading zero implied
    logic [3:0] low_load_max; // bits 18..15
    logic [4:0] stby; // bits 14..10
    logic [4:0] scaling; // bits 9..5
    logic [4:0] normal; // bits 4..0
  } bssr_buck_two_type;

  typedef struct packed {
    logic range_sel; // bit 23
    logic [7:0] zero; // bits 22..15, read as zero
    logic [4:0] stby; // bits 14..10
    logic [4:0] spare; // bits 9..5
    logic [4:0] normal; // bits 4..0
  } bssr_buck_lo_type;

  typedef struct packed {
    logic rsvd_hi; // bit 23, reads zero
    logic ilim_dis; // bit 22
    logic [2:0] pll_mult; // bits 21..19
    logic pll_en; // bit 18
    logic [1:0] speed2; // bits 17..16
    logic uo2; // bit 15
    logic mh2; // bit 14
    logic [3:0] mode2; // bits 13..10
    logic rsvd_lo; // bit 9, reads zero
    logic low_load_scaling_enable; // bit 8
    logic [1:0] speed1; // bits 7..6
    logic uo1; // bit 5
    logic mh1; // bit 4
    logic [3:0] mode1; // bits 3..0
  } bssr_mode_ctl_type;

endpackage

/* File: rtl/bssr_pin_sync.sv */
// three-stage synchroniser with agreement filter for reset pins
// assumes the pins are asynchronous to mclk and rst is synchronous

`timescale 1ns/1ps

module bssr_pin_sync #(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] IDLE = '1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);

  // ----------------------------------------------------------------
  // stages
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q; // s1 feeds s2 and nothing else
  logic [WIDTH-1:0] s1_d, s2_d, s3_d, out_d;

  // next values: output moves only when second and third stage agree
  always_comb begin
    s1_d = pin_in;
    s2_d = s1_q;
    s3_d = s2_q;
    out_d = out_q;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        out_d[i] = s3_q[i];
      end
    end
    if (rst) begin
      s1_d = IDLE;
      s2_d = IDLE;
      s3_d = IDLE;
      out_d = IDLE;
    end
  end

  // registers only
  always_ff @(posedge mclk) begin
    s1_q <= s1_d;
    s2_q <= s2_d;
    s3_q <= s3_d;
    out_q <= out_d;
  end

  assign pin_out = out_q;

  // output follows the settled third stage one edge later
  a_sync_follow: assert property (@(posedge mclk) disable iff (rst)
    (s2_q == s3_q) |=> (pin_out == $past(s3_q)))
    else $error("synchroniser output did not follow agreed stage");

endmodule

/* File: sim/testbench.sv */
// self-checking bench for the buck switcher setting register bank
// assumes bssr_regs alone, every input driven at falling mclk edges
`timescale 1ns/1ps
module testbench;
  import bssr_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and observation signals
  // ----------------------------------------------------------------
  logic mclk = 1'b0; // 20 MHz core clock
  logic rst = 1'b1; // core power-up reset
  logic system_reset_n = 1'b1; // pin idles high
  logic power_off_reset_n = 1'b1; // pin idles high
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [23:0] reg_wdata = 24'h000000;
  logic [23:0] reg_rdata;
  logic reg_rvalid;
  logic seq_restore = 1'b0;
  logic [1:0] buck_startup_enable = 2'h0;
  bssr_buck_two_type cfg_buck_two = '0;
  bssr_buck_lo_type cfg_buck_three = '0;
  bssr_buck_lo_type cfg_buck_four = '0;
  bssr_buck_two_type buck_two_set;
  bssr_buck_lo_type buck_three_set;
  bssr_buck_lo_type buck_four_set;
  bssr_mode_ctl_type switcher_mode;
  logic [23:0] mdl [4]; // expected word per register, 0x19 first
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;
  int seed_init;

  bssr_regs i_bssr_regs (
    .mclk(mclk), .rst(rst), .system_reset_n(system_reset_n),
    .power_off_reset_n(power_off_reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .seq_restore(seq_restore),
    .buck_startup_enable(buck_startup_enable), .cfg_buck_two(cfg_buck_two),
    .cfg_buck_three(cfg_buck_three), .cfg_buck_four(cfg_buck_four),
    .buck_two_set(buck_two_set), .buck_three_set(buck_three_set),
    .buck_four_set(buck_four_set), .switcher_mode(switcher_mode)
  );

  // ----------------------------------------------------------------
  // clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    forever #25 mclk = ~mclk;
  end

  // whole run is well under 2000 cycles
  always @(posedge mclk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // expectation helpers and bus tasks
  // ----------------------------------------------------------------
  // writable bits: all of 0x19, range/standby/normal/spare, mode minus zero bits
  function automatic logic [23:0] wmask(input int idx);
    return (idx == 0) ? 24'hffffff : (idx == 3) ? 24'h7ffdff : 24'h807fff;
  endfunction

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one-cycle write strobe, then an idle cycle so strobes never meet
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    int idx;
    idx = int'(a) - 8'h19;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    if (idx >= 0 && idx < 4) begin
      mdl[idx] = (mdl[idx] & ~wmask(idx)) | (d & wmask(idx));
    end
    @(negedge mclk);
  endtask

  // answer one cycle after the strobe, data then holds
  task automatic rd(input logic [7:0] a, input logic [23:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    chk({23'h0, reg_rvalid}, 24'h000001);
    chk(reg_rdata, exp);
    @(negedge mclk);
    chk({23'h0, reg_rvalid}, 24'h000000);
    chk(reg_rdata, exp);
  endtask

  task automatic chk_all();
    for (int i = 0; i < 4; i++) begin
      rd(8'h19 + 8'(i), mdl[i]);
    end
    chk(buck_two_set, mdl[0]);
    chk(buck_three_set, mdl[1]);
    chk(buck_four_set, mdl[2]);
    chk(switcher_mode, mdl[3]);
  endtask

  // core reset loads defaults and configuration; cfg changes afterwards
  task automatic do_reset();
    cfg_buck_two = 24'($urandom);
    cfg_buck_three = 24'($urandom);
    cfg_buck_four = 24'($urandom);
    rst = 1'b1;
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    mdl[0] = (cfg_buck_two & ~24'h7f8000) | 24'h450000;
    mdl[1] = cfg_buck_three & 24'h807fff;
    mdl[2] = cfg_buck_four & 24'h807fff;
    mdl[3] = 24'h21284a;
    cfg_buck_two = 24'($urandom);
    cfg_buck_three = 24'($urandom);
    cfg_buck_four = 24'($urandom);
  endtask

  // pins pass a synchroniser, so hold low long enough and settle after
  task automatic pin_pulse(input logic sys, input logic off);
    system_reset_n = ~sys;
    power_off_reset_n = ~off;
    repeat (8) @(negedge mclk);
    system_reset_n = 1'b1;
    power_off_reset_n = 1'b1;
    repeat (8) @(negedge mclk);
    if (sys) begin
      mdl[0] = (mdl[0] & ~24'h7f8000) | 24'h450000;
      mdl[3] = (mdl[3] & 24'h00c030) | 24'h21284a;
    end
    if (off) begin
      mdl[3] = mdl[3] & ~24'h00c030;
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] a;
    logic [23:0] d;
    seed_init = $urandom(86);
    do_reset();
    chk_all();
    rd(8'h18, 24'h000000);
    // corner words: every bit set, then every bit cleared
    for (int i = 0; i < 4; i++) begin
      wr(8'h19 + 8'(i), 24'hffffff);
    end
    chk_all();
    for (int i = 0; i < 4; i++) begin
      wr(8'h19 + 8'(i), 24'h000000);
    end
    chk_all();
    // random traffic, one in five to an unmapped place
    for (int n = 0; n < 60; n++) begin
      a = ($urandom % 5 == 4) ? (8'h20 | 8'($urandom % 32)) : 8'h19 + 8'($urandom % 4);
      d = 24'($urandom);
      wr(a, d);
      rd(a, (a < 8'h20) ? mdl[a - 8'h19] : 24'h000000);
    end
    chk_all();
    // system reset keeps hold and user-off bits set beforehand
    wr(8'h1c, 24'hffffff);
    pin_pulse(1'b1, 1'b0);
    chk_all();
    pin_pulse(1'b0, 1'b1);
    chk_all();
    // startup restore for every enable pattern
    for (int e = 0; e < 4; e++) begin
      buck_startup_enable = 2'(e);
      seq_restore = 1'b1;
      @(negedge mclk);
      seq_restore = 1'b0;
      mdl[3][3:0] = e[0] ? 4'ha : 4'h0;
      mdl[3][13:10] = e[1] ? 4'ha : 4'h0;
      chk(switcher_mode, mdl[3]);
      @(negedge mclk);
    end
    chk_all();
    // second core reset in mid-run
    do_reset();
    chk_all();
    results();
  end
endmodule
